// ### rtl/element_status_pkg.sv
// constants and types shared by the element status report block
//------------------------------------------------------------------
// What this block does
// - type selector: 0 all, 1/2/4 types, 3 unsupported
// - report only defined elements from starting address
// - any valid start address accepted, any type
// - bad start: check condition, 5/24h/00, pointer 2
// - element count caps descriptors created
// - only whole descriptors fit allocation length
// - count beyond existing: send all, then end
// - allocation length caps bytes; zero is fine
// - report header, then one page per type with descriptors
// - header bytes 0-1: first reported address
// - header bytes 2-3: elements available, uncut
// - header bytes 5-7: page data bytes, uncut
// - page byte 0: element type code
// - page volume tag flags always zero
// - page bytes 2-3: descriptor length
// - page bytes 5-7: descriptor bytes, uncut
//------------------------------------------------------------------
package element_status_pkg;

  // element type codes
  localparam logic [3:0]  TYPE_ALL       = 4'h0;
  localparam logic [3:0]  TYPE_TRANSPORT = 4'h1;
  localparam logic [3:0]  TYPE_SLOT      = 4'h2;
  localparam logic [3:0]  TYPE_DRIVE     = 4'h4;

  // element map, one transport, ten slots, one drive
  localparam logic [15:0] TRANSPORT_ADDR = 16'h0000;
  localparam logic [15:0] SLOT_BASE_ADDR = 16'h0001;
  localparam logic [15:0] SLOT_LAST_ADDR = 16'h000a;
  localparam logic [15:0] DRIVE_ADDR     = 16'h000b;
  localparam logic [3:0]  SLOT_FIRST_IDX = 4'h1;
  localparam logic [3:0]  SLOT_LAST_IDX  = 4'ha;
  localparam logic [3:0]  DRIVE_IDX      = 4'hb;

  // layout of reply
  localparam logic [7:0]  DESC_LEN       = 8'h10;
  localparam logic [7:0]  HDR_LEN        = 8'h08;
  localparam logic [3:0]  HDR_LAST_OFF   = 4'h7;
  localparam logic [3:0]  DESC_LAST_OFF  = 4'hf;
  localparam logic [7:0]  SLOT_ACCESS    = 8'h08;

  // sense data for refused commands
  localparam logic [3:0]  KEY_ILLEGAL    = 4'h5;
  localparam logic [7:0]  ASC_BAD_FIELD  = 8'h24;
  localparam logic [7:0]  ASCQ_NONE      = 8'h00;
  localparam logic [15:0] PTR_TYPE       = 16'h0001;
  localparam logic [15:0] PTR_START      = 16'h0002;

  typedef struct packed {
    logic        vol_tag_req;
    logic [3:0]  type_code;
    logic [15:0] start_addr;
    logic [15:0] num_elems;
    logic [23:0] alloc_len;
  } cdb_type;

  typedef struct packed {
    logic        check;
    logic [3:0]  sense_key;
    logic [7:0]  asc;
    logic [7:0]  ascq;
    logic [15:0] field_ptr;
  } status_type;

  localparam status_type STATUS_GOOD = '0;

endpackage

// ### rtl/element_table.sv
// element map lookup and descriptor byte former
`timescale 1ns/1ns
module element_table (
  input  wire logic [3:0]  idx,
  input  wire logic [3:0]  off,
  output logic      [15:0] elem_addr,
  output logic      [3:0]  elem_type,
  output logic      [7:0]  desc_byte
);

  // index 0 transport, 1..10 slots, 11 drive
  always_comb begin
    if (idx == 4'h0) begin
      elem_addr = element_status_pkg::TRANSPORT_ADDR;
      elem_type = element_status_pkg::TYPE_TRANSPORT;
    end else if (idx == element_status_pkg::DRIVE_IDX) begin
      elem_addr = element_status_pkg::DRIVE_ADDR;
      elem_type = element_status_pkg::TYPE_DRIVE;
    end else begin
      elem_addr = element_status_pkg::SLOT_BASE_ADDR + 16'(idx) - 16'h0001;
      elem_type = element_status_pkg::TYPE_SLOT;
    end
  end

  // descriptor: address, slot access bit, rest zero
  always_comb begin
    case (off)
      4'h0: desc_byte = elem_addr[15:8];
      4'h1: desc_byte = elem_addr[7:0];
      4'h2: desc_byte = (elem_type == element_status_pkg::TYPE_SLOT) ?
                        element_status_pkg::SLOT_ACCESS : 8'h00;
      default: desc_byte = 8'h00;
    endcase
  end

endmodule // element_table

// ### rtl/element_status_report.sv
// command handler that builds the element status reply
`timescale 1ns/1ns
module element_status_report (
  input  wire logic                           core_clk,
  input  wire logic                           arst_n,
  input  wire logic                           cmd_valid,
  input  wire element_status_pkg::cdb_type    cmd_cdb,
  output logic                                cmd_ready,
  output logic                                din_valid,
  output logic      [7:0]                     din_byte,
  input  wire logic                           din_ready,
  output logic                                done,
  output element_status_pkg::status_type      status
);

  //----------------------------------------------------------------
  // types, registers and helpers
  //----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_SCAN, ST_RHDR, ST_PHDR, ST_DESC, ST_END
  } state_type;

  state_type                       state_reg;
  element_status_pkg::cdb_type     cdb_reg;
  element_status_pkg::status_type  status_reg;
  logic [3:0]                      idx_reg;
  logic [3:0]                      off_reg;
  logic [1:0]                      pg_reg;
  logic [23:0]                     sent_reg;
  logic [15:0]                     taken_reg;
  logic [2:0][3:0]                 cnt_reg;
  logic [11:0]                     mask_reg;
  logic [15:0]                     first_reg;
  logic                            din_valid_reg;
  logic [7:0]                      din_byte_reg;
  logic                            done_reg;
  logic                            cmd_ready_reg;

  logic [15:0] cur_addr;
  logic [3:0]  cur_type;
  logic [7:0]  cur_desc;
  logic        accept;
  logic        bad_type;
  logic        bad_start;
  logic        pick;
  logic        slot_free;
  logic        budget;
  logic        fits;
  logic        emit;
  logic        desc_step;
  logic        end_now;
  logic [2:0]  first_pg;
  logic [2:0]  after_pg;
  logic [23:0] rep_bytes;
  logic [23:0] pg_bytes;
  logic [7:0]  hdr_byte;

  // page index to type code; fixed order transport, slot, drive
  function automatic logic [3:0] pg_type(input logic [1:0] pg);
    case (pg)
      2'h0: pg_type = element_status_pkg::TYPE_TRANSPORT;
      2'h1: pg_type = element_status_pkg::TYPE_SLOT;
      default: pg_type = element_status_pkg::TYPE_DRIVE;
    endcase
  endfunction

  // type code to page index
  function automatic logic [1:0] type_pg(input logic [3:0] t);
    case (t)
      element_status_pkg::TYPE_TRANSPORT: type_pg = 2'h0;
      element_status_pkg::TYPE_SLOT: type_pg = 2'h1;
      default: type_pg = 2'h2;
    endcase
  endfunction

  // first and last element index of a page
  function automatic logic [3:0] pg_first(input logic [1:0] pg);
    case (pg)
      2'h0: pg_first = 4'h0;
      2'h1: pg_first = element_status_pkg::SLOT_FIRST_IDX;
      default: pg_first = element_status_pkg::DRIVE_IDX;
    endcase
  endfunction

  function automatic logic [3:0] pg_last(input logic [1:0] pg);
    case (pg)
      2'h0: pg_last = 4'h0;
      2'h1: pg_last = element_status_pkg::SLOT_LAST_IDX;
      default: pg_last = element_status_pkg::DRIVE_IDX;
    endcase
  endfunction

  // next page at or after 'from' holding descriptors; bit 2 = found
  function automatic logic [2:0] next_pg(input logic [2:0] from,
                                         input logic [2:0][3:0] cnt);
    next_pg = 3'h0;
    for (int p = 2; p >= 0; p--) begin
      if (3'(p) >= from && cnt[p] != 4'h0) begin
        next_pg = {1'b1, 2'(p)};
      end
    end
  endfunction

  // descriptor bytes of one page, never cut to allocation
  function automatic logic [23:0] page_bytes(input logic [3:0] cnt);
    page_bytes = 24'({cnt, 4'h0});
  endfunction

  // both headers share one layout of two words and a 24-bit count
  function automatic logic [7:0] hdr_pick(input logic [3:0] off,
                                          input logic [15:0] w0,
                                          input logic [15:0] w1,
                                          input logic [23:0] w2);
    case (off)
      4'h0: hdr_pick = w0[15:8];
      4'h1: hdr_pick = w0[7:0];
      4'h2: hdr_pick = w1[15:8];
      4'h3: hdr_pick = w1[7:0];
      4'h5: hdr_pick = w2[23:16];
      4'h6: hdr_pick = w2[15:8];
      4'h7: hdr_pick = w2[7:0];
      default: hdr_pick = 8'h00;
    endcase
  endfunction

  // any defined address is a valid start, of whatever type
  function automatic logic addr_ok(input logic [15:0] a);
    addr_ok = (a == element_status_pkg::TRANSPORT_ADDR) ||
              (a == element_status_pkg::DRIVE_ADDR) ||
              (a >= element_status_pkg::SLOT_BASE_ADDR &&
               a <= element_status_pkg::SLOT_LAST_ADDR);
  endfunction

  element_table u_table (
    .idx       (idx_reg),
    .off       (off_reg),
    .elem_addr (cur_addr),
    .elem_type (cur_type),
    .desc_byte (cur_desc)
  );

  //----------------------------------------------------------------
  // decode and flow terms
  //----------------------------------------------------------------
  // command checks, taken straight off the request
  // selector decode check
  assign bad_type = !(cmd_cdb.type_code == element_status_pkg::TYPE_ALL ||
                      cmd_cdb.type_code == element_status_pkg::TYPE_TRANSPORT ||
                      cmd_cdb.type_code == element_status_pkg::TYPE_SLOT ||
                      cmd_cdb.type_code == element_status_pkg::TYPE_DRIVE);
  assign bad_start = !addr_ok(cmd_cdb.start_addr);
  assign accept    = cmd_valid && cmd_ready_reg;

  // type and start filter; map holds defined only
  assign pick = (cdb_reg.type_code == element_status_pkg::TYPE_ALL ||
                 cdb_reg.type_code == cur_type) &&
                cur_addr >= cdb_reg.start_addr &&
                taken_reg < cdb_reg.num_elems;

  // sum of pages with their headers, uncut
  always_comb begin
    rep_bytes = 24'h0;
    for (int p = 0; p < 3; p++) begin
      if (cnt_reg[p] != 4'h0) begin
        rep_bytes = rep_bytes + 24'(element_status_pkg::HDR_LEN) +
                    page_bytes(cnt_reg[p]);
      end
    end
  end

  assign pg_bytes = page_bytes(cnt_reg[pg_reg]);
  assign first_pg = next_pg(3'h0, cnt_reg);
  assign after_pg = next_pg(3'({1'b0, pg_reg}) + 3'h1, cnt_reg);

  // output stage takes a byte when empty or drained this cycle
  assign slot_free = !din_valid_reg || din_ready;
  // bytes stop at the allocation length
  assign budget    = sent_reg < cdb_reg.alloc_len;
  // a descriptor starts only if all of it fits
  assign fits = (25'(sent_reg) + 25'(element_status_pkg::DESC_LEN)) <=
                25'(cdb_reg.alloc_len);

  always_comb begin
    case (state_reg)
      ST_RHDR, ST_PHDR: emit = slot_free && budget;
      ST_DESC: emit = slot_free && mask_reg[idx_reg] &&
                      (off_reg != 4'h0 || fits);
      default: emit = 1'b0;
    endcase
  end

  // leave an element: skipped, or its last byte just went out
  assign desc_step = (state_reg == ST_DESC) &&
                     (!mask_reg[idx_reg] ||
                      (emit && off_reg == element_status_pkg::DESC_LAST_OFF));
  assign end_now   = (state_reg == ST_END) && slot_free;

  // header byte for the state in hand
  // report header fields, else page header fields
  always_comb begin
    if (state_reg == ST_RHDR) begin
      hdr_byte = hdr_pick(off_reg, first_reg, taken_reg, rep_bytes);
    end else begin
      hdr_byte = hdr_pick(off_reg, {4'h0, pg_type(pg_reg), 8'h00},
                          {8'h00, element_status_pkg::DESC_LEN}, pg_bytes);
    end
  end

  //----------------------------------------------------------------
  // sequencing
  //----------------------------------------------------------------
  // walk: scan the map, then report header, pages and descriptors
  // header then one page per type with descriptors
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
      idx_reg   <= 4'h0;
      off_reg   <= 4'h0;
      pg_reg    <= 2'h0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (accept) begin
            idx_reg <= 4'h0;
            off_reg <= 4'h0;
            // refused commands skip the data phase
            state_reg <= (bad_type || bad_start) ? ST_END : ST_SCAN;
          end
        end
        ST_SCAN: begin
          if (idx_reg == element_status_pkg::DRIVE_IDX) begin
            state_reg <= ST_RHDR;
          end else begin
            idx_reg <= idx_reg + 4'h1;
          end
        end
        ST_RHDR, ST_PHDR: begin
          if (!budget) begin
            state_reg <= ST_END;
          end else if (emit && off_reg == element_status_pkg::HDR_LAST_OFF) begin
            off_reg <= 4'h0;
            if (state_reg == ST_PHDR) begin
              idx_reg   <= pg_first(pg_reg);
              state_reg <= ST_DESC;
            end else if (first_pg[2]) begin
              pg_reg    <= first_pg[1:0];
              state_reg <= ST_PHDR;
            end else begin
              state_reg <= ST_END;
            end
          end else if (emit) begin
            off_reg <= off_reg + 4'h1;
          end
        end
        ST_DESC: begin
          if (desc_step) begin
            off_reg <= 4'h0;
            if (idx_reg != pg_last(pg_reg)) begin
              idx_reg <= idx_reg + 4'h1;
            end else if (after_pg[2]) begin
              pg_reg    <= after_pg[1:0];
              state_reg <= ST_PHDR;
            end else begin
              // all existing sent, data phase ends
              state_reg <= ST_END;
            end
          end else if (off_reg == 4'h0 && !fits) begin
            // no room for a whole descriptor
            state_reg <= ST_END;
          end else if (emit) begin
            off_reg <= off_reg + 4'h1;
          end
        end
        ST_END: begin
          if (slot_free) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // selection state built while scanning the map
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cdb_reg   <= '0;
      taken_reg <= 16'h0;
      cnt_reg   <= '0;
      mask_reg  <= 12'h0;
      first_reg <= 16'h0;
    end else if (accept) begin
      cdb_reg   <= cmd_cdb;
      taken_reg <= 16'h0;
      cnt_reg   <= '0;
      mask_reg  <= 12'h0;
      first_reg <= 16'h0;
    end else if (state_reg == ST_SCAN && pick) begin
      mask_reg[idx_reg]          <= 1'b1;
      taken_reg                  <= taken_reg + 16'h1;
      cnt_reg[type_pg(cur_type)] <= cnt_reg[type_pg(cur_type)] + 4'h1;
      // map runs in rising address, so the first pick is the smallest
      if (taken_reg == 16'h0) begin
        first_reg <= cur_addr;
      end
    end
  end

  // byte stream; one output stage, stalls on din_ready
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      din_valid_reg <= 1'b0;
      din_byte_reg  <= 8'h00;
      sent_reg      <= 24'h0;
    end else begin
      if (accept) begin
        sent_reg <= 24'h0;
      end else if (emit) begin
        sent_reg <= sent_reg + 24'h1;
      end
      if (emit) begin
        din_valid_reg <= 1'b1;
        din_byte_reg  <= (state_reg == ST_DESC) ? cur_desc : hdr_byte;
      end else if (din_ready) begin
        din_valid_reg <= 1'b0;
      end
    end
  end

  // completion, status and readiness
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      status_reg    <= element_status_pkg::STATUS_GOOD;
      done_reg      <= 1'b0;
      cmd_ready_reg <= 1'b0;
    end else begin
      done_reg      <= end_now;
      cmd_ready_reg <= (state_reg == ST_IDLE && !accept) || end_now;
      if (accept) begin
        if (bad_type) begin
          status_reg <= {1'b1, element_status_pkg::KEY_ILLEGAL,
                         element_status_pkg::ASC_BAD_FIELD,
                         element_status_pkg::ASCQ_NONE,
                         element_status_pkg::PTR_TYPE};
        end else if (bad_start) begin
          // illegal request, pointer at byte 2
          status_reg <= {1'b1, element_status_pkg::KEY_ILLEGAL,
                         element_status_pkg::ASC_BAD_FIELD,
                         element_status_pkg::ASCQ_NONE,
                         element_status_pkg::PTR_START};
        end else begin
          status_reg <= element_status_pkg::STATUS_GOOD;
        end
      end
    end
  end

  assign cmd_ready = cmd_ready_reg;
  assign din_valid = din_valid_reg;
  assign din_byte  = din_byte_reg;
  assign done      = done_reg;
  assign status    = status_reg;

  //----------------------------------------------------------------
  // checks
  //----------------------------------------------------------------
  default clocking ck @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence s_quiet;
    (!din_valid_reg) [*8];
  endsequence

  sequence s_refused(logic [15:0] ptr);
    ##[1:4] (done_reg && status_reg.check && status_reg.field_ptr == ptr &&
             status_reg.sense_key == 4'h5 && status_reg.asc == 8'h24 &&
             status_reg.ascq == 8'h00);
  endsequence

  type_refused_a: assert property (
    accept && cmd_cdb.type_code == 4'h3 |-> s_refused(16'h0001)
  ) else $error("unsupported type not refused");

  start_refused_a: assert property (
    accept && !bad_type && !addr_ok(cmd_cdb.start_addr) |->
      !din_valid_reg ##0 s_refused(16'h0002)
  ) else $error("invalid start not refused");

  zero_alloc_a: assert property (
    accept && !bad_type && !bad_start && cmd_cdb.alloc_len == 24'h0 |=>
      s_quiet ##[1:12] done_reg
  ) else $error("zero allocation sent data or hung");

  alloc_bound_a: assert property (
    sent_reg <= cdb_reg.alloc_len || state_reg == ST_IDLE
  ) else $error("bytes beyond allocation length");

  whole_desc_a: assert property (
    state_reg == ST_DESC && emit && off_reg == 4'h0 |->
      25'(sent_reg) + 25'h10 <= 25'(cdb_reg.alloc_len)
  ) else $error("descriptor started without room");

  count_cap_a: assert property (
    state_reg != ST_IDLE |-> taken_reg <= cdb_reg.num_elems
  ) else $error("more elements than requested");

  page_type_a: assert property (
    state_reg == ST_PHDR && emit && off_reg == 4'h0 |=>
      din_byte_reg == {4'h0, pg_type(pg_reg)}
  ) else $error("page type byte wrong");

  vol_flags_a: assert property (
    state_reg == ST_PHDR && emit && off_reg == 4'h1 |=> din_byte_reg == 8'h00
  ) else $error("volume tag flags not zero");

  first_addr_a: assert property (
    state_reg == ST_RHDR && emit && off_reg == 4'h1 |=>
      din_byte_reg == first_reg[7:0] && first_reg >= cdb_reg.start_addr
  ) else $error("first address byte wrong");

  report_count_a: assert property (
    state_reg == ST_RHDR && emit && off_reg == 4'h7 |=>
      din_byte_reg == rep_bytes[7:0]
  ) else $error("report byte count wrong");

endmodule // element_status_report

// ### tb/initiator_model.sv
// initiator model: issues commands and takes data-in bytes
`timescale 1ns/1ns
module initiator_model (
  input  wire logic                   core_clk,
  input  wire logic                   arst_n,
  input  wire logic                   cmd_ready,
  input  wire logic                   din_valid,
  input  wire logic [7:0]             din_byte,
  input  wire logic                   done,
  output logic                        cmd_valid,
  output element_status_pkg::cdb_type cmd_cdb,
  output logic                        din_ready
);
  logic [7:0] rx_q[$];
  int         done_count;
  logic       slow;

  // quiet bus at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_cdb = '0;
    slow = 1'b0;
    done_count = 0;
  end

  // hold the command until an edge samples cmd_ready high
  task automatic send_cmd(input element_status_pkg::cdb_type c);
    element_status_pkg::cdb_type v;
    v = c;
    v.vol_tag_req = 1'b0;
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_cdb <= v;
    do @(posedge core_clk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    // released block shows garbage, not the last command
    cmd_cdb <= ~v;
  endtask

  // slow mode stalls every other cycle
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) din_ready <= 1'b0;
    else din_ready <= slow ? ~din_ready : 1'b1;
  end

  // take bytes and count completions
  always @(posedge core_clk) begin
    if (din_valid === 1'b1 && din_ready === 1'b1) rx_q.push_back(din_byte);
    if (done === 1'b1) done_count <= done_count + 1;
  end
endmodule // initiator_model

// ### tb/testbench.sv
// self-checking bench for the element status report block
`timescale 1ns/1ns
module testbench;
  logic                           core_clk;
  logic                           arst_n;
  logic                           cmd_valid;
  logic                           cmd_ready;
  logic                           din_valid;
  logic                           din_ready;
  logic                           done;
  logic [7:0]                     din_byte;
  element_status_pkg::cdb_type    cmd_cdb;
  element_status_pkg::status_type status;
  element_status_pkg::status_type exp_st;
  logic [7:0]                     exp_q[$];
  logic                           stop;
  int                             lim;
  int                             n_errors;
  int                             check_count;

  element_status_report uut (.core_clk, .arst_n, .cmd_valid, .cmd_cdb, .cmd_ready,
    .din_valid, .din_byte, .din_ready, .done, .status);
  initiator_model host (.core_clk, .arst_n, .cmd_ready, .din_valid, .din_byte, .done,
    .cmd_valid, .cmd_cdb, .din_ready);

  //--------------------------------------------------------------
  // helpers
  //--------------------------------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // bytes past the allocation are dropped; a descriptor goes whole or not at all
  task automatic put(input logic [7:0] b);
    if (!stop && exp_q.size() < lim) exp_q.push_back(b);
  endtask

  task automatic build_exp(input element_status_pkg::cdb_type c);
    logic [15:0] sel[$];
    logic [3:0]  codes[3];
    int          n[3];
    int          k;
    int          j;
    logic [23:0] tot;
    exp_q.delete();
    stop = 1'b0;
    lim = int'(c.alloc_len);
    n = '{0, 0, 0};
    codes = '{element_status_pkg::TYPE_TRANSPORT, element_status_pkg::TYPE_SLOT,
              element_status_pkg::TYPE_DRIVE};
    exp_st = {1'b1, element_status_pkg::KEY_ILLEGAL, element_status_pkg::ASC_BAD_FIELD,
              element_status_pkg::ASCQ_NONE, element_status_pkg::PTR_TYPE};
    if (!(c.type_code inside {4'h0, 4'h1, 4'h2, 4'h4})) return;
    exp_st.field_ptr = element_status_pkg::PTR_START;
    if (c.start_addr > element_status_pkg::DRIVE_ADDR) return;
    exp_st = element_status_pkg::STATUS_GOOD;
    // element map ascends transport, slots, drive
    for (int a = 0; a <= int'(element_status_pkg::DRIVE_ADDR); a++) begin
      k = (a == 0) ? 0 : (a == int'(element_status_pkg::DRIVE_ADDR)) ? 2 : 1;
      if (a >= int'(c.start_addr) && (c.type_code == 4'h0 || c.type_code == codes[k])
          && sel.size() < int'(c.num_elems)) begin
        sel.push_back(a[15:0]);
        n[k]++;
      end
    end
    tot = 24'(8 * ((n[0] > 0) + (n[1] > 0) + (n[2] > 0)) + 16 * sel.size());
    put(sel[0][15:8]);
    put(sel[0][7:0]);
    put(8'h00);
    put(8'(sel.size()));
    put(8'h00);
    put(tot[23:16]);
    put(tot[15:8]);
    put(tot[7:0]);
    j = 0;
    for (k = 0; k < 3; k++) begin
      if (n[k] > 0) begin
        foreach (codes[i]) put(i == 0 ? {4'h0, codes[k]} : 8'h00);
        put(element_status_pkg::DESC_LEN);
        // reserved byte 4, then descriptor byte count in bytes 5 to 7
        repeat (3) put(8'h00);
        put(8'(16 * n[k]));
        for (int m = 0; m < n[k]; m++) begin
          if (exp_q.size() + 16 > lim) stop = 1'b1;
          put(sel[j][15:8]);
          put(sel[j][7:0]);
          put(k == 1 ? element_status_pkg::SLOT_ACCESS : 8'h00);
          repeat (13) put(8'h00);
          j++;
        end
      end
    end
  endtask

  // one command, then judge status, completion and every byte
  task automatic run(input logic [3:0] t, input logic [15:0] st, input logic [15:0] ne,
                     input logic [23:0] al, input logic sl);
    element_status_pkg::cdb_type c;
    int d0;
    int i;
    c = {1'b0, t, st, ne, al};
    build_exp(c);
    host.rx_q.delete();
    host.slow = sl;
    d0 = host.done_count;
    host.send_cmd(c);
    for (i = 0; i < 3000 && host.done_count == d0; i++) @(posedge core_clk);
    repeat (3) @(posedge core_clk);
    chk(64'(host.done_count - d0), 64'h1);
    chk(64'(cmd_ready), 64'h1);
    chk(64'(status), 64'(exp_st));
    chk(64'(host.rx_q.size()), 64'(exp_q.size()));
    foreach (exp_q[b]) if (b < host.rx_q.size()) chk(64'(host.rx_q[b]), 64'(exp_q[b]));
  endtask

  //--------------------------------------------------------------
  // scenarios
  //--------------------------------------------------------------
  task automatic test_all();
    run(4'h0, 16'h0000, 16'h0063, 24'h000400, 1'b0);
    run(4'h0, 16'h0000, 16'h0063, 24'h000400, 1'b1);
  endtask

  task automatic test_types();
    for (int t = 1; t < 6; t++) run(4'(t), 16'h0000, 16'h0063, 24'h000400, t[0]);
    run(4'hf, 16'h0000, 16'h0063, 24'h000400, 1'b0);
  endtask

  task automatic test_start();
    run(4'h4, 16'h0002, 16'h0063, 24'h000400, 1'b0);
    run(4'h2, 16'h0005, 16'h0063, 24'h000400, 1'b1);
    run(4'h0, 16'h000b, 16'h0063, 24'h000400, 1'b0);
    run(4'h2, 16'h000c, 16'h0063, 24'h000400, 1'b0);
    run(4'h0, 16'hffff, 16'h0001, 24'h000400, 1'b0);
  endtask

  task automatic test_count();
    run(4'h2, 16'h0001, 16'h0003, 24'h000400, 1'b0);
    run(4'h0, 16'h0000, 16'h0001, 24'h000400, 1'b1);
  endtask

  task automatic test_alloc();
    logic [23:0] cnt;
    run(4'h0, 16'h0000, 16'h0063, 24'h000000, 1'b0);
    run(4'h0, 16'h0000, 16'h0063, 24'h000005, 1'b1);
    run(4'h0, 16'h0000, 16'h0063, 24'h00003c, 1'b0);
    run(4'h2, 16'h0000, 16'h0063, 24'h000047, 1'b1);
    run(4'h0, 16'h0000, 16'h0063, 24'h000008, 1'b0);
    cnt = {host.rx_q[5], host.rx_q[6], host.rx_q[7]};
    run(4'h0, 16'h0000, 16'h0063, cnt + 24'h000008, 1'b0);
  endtask

  task automatic print_verdict();
    if (n_errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // 50 ns clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // watchdog well past the longest expected run
  initial begin
    #3000000;
    n_errors++;
    print_verdict();
  end

  initial begin
    n_errors = 0;
    check_count = 0;
    arst_n = 1'b0;
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    test_all();
    test_types();
    test_start();
    test_count();
    test_alloc();
    print_verdict();
  end
endmodule // testbench
